// File: hdl/periph_disable_params.svh
// Offsets, field positions, reset values and counts of the disable bank
`ifndef PERIPH_DISABLE_PARAMS_SVH
`define PERIPH_DISABLE_PARAMS_SVH

// Register indices; byte address is four times the index
`define PDC_IDX_DISABLE0 12'h010C
`define PDC_IDX_DISABLE1 12'h010D
`define PDC_IDX_DISABLE2 12'h010E
`define PDC_IDX_DISABLE3 12'h010F
`define PDC_IDX_READY0 12'h0120
`define PDC_IDX_READY1 12'h0121
`define PDC_IDX_READY2 12'h0122
`define PDC_IDX_READY3 12'h0123
`define PDC_ADDR_DISABLE0 12'h0430
`define PDC_ADDR_DISABLE1 12'h0434
`define PDC_ADDR_DISABLE2 12'h0438
`define PDC_ADDR_DISABLE3 12'h043C
`define PDC_ADDR_READY0 12'h0480
`define PDC_ADDR_READY1 12'h0484
`define PDC_ADDR_READY2 12'h0488
`define PDC_ADDR_READY3 12'h048C

// Reset values and implemented-bit masks, one byte per register
`define PDC_DISABLE_RESET 32'h0000_0000
`define PDC_IMPL_MASK0 8'hFF
`define PDC_IMPL_MASK1 8'hEF
`define PDC_IMPL_MASK2 8'hF9
`define PDC_IMPL_MASK3 8'hFF

// Bit positions within the flat 32-bit disable vector {r3, r2, r1, r0}
`define PDC_BIT_NONVOLATILE_ACCESS 0
`define PDC_BIT_CHECKSUM_UNIT 1
`define PDC_BIT_MEMORY_SCANNER 2
`define PDC_BIT_SYSTEM_CLOCK_NET 3
`define PDC_BIT_CLOCK_TUNING 4
`define PDC_BIT_PIN_CHANGE_IRQ 5
`define PDC_BIT_CLOCK_REFERENCE 6
`define PDC_BIT_TIMER_ZERO 7
`define PDC_BIT_TIMER_ONE 8
`define PDC_BIT_TIMER_THREE 9
`define PDC_BIT_TIMER_TWO 10
`define PDC_BIT_TIMER_FOUR 11
`define PDC_BIT_CAPTURE_COMPARE_ONE 13
`define PDC_BIT_CAPTURE_COMPARE_TWO 14
`define PDC_BIT_PULSE_WIDTH_ONE 15
`define PDC_BIT_PULSE_WIDTH_TWO 16
`define PDC_BIT_NUMERIC_OSC_ONE 19
`define PDC_BIT_WAVEFORM_GEN_ONE 20
`define PDC_BIT_LOGIC_CELL_ONE 21
`define PDC_BIT_LOGIC_CELL_TWO 22
`define PDC_BIT_LOGIC_CELL_THREE 23
`define PDC_BIT_LOGIC_CELL_FOUR 24
`define PDC_BIT_ASYNC_SERIAL_ONE 25
`define PDC_BIT_ASYNC_SERIAL_TWO 26
`define PDC_BIT_SERIAL_PORT_ONE 27
`define PDC_BIT_SERIAL_PORT_TWO 28
`define PDC_BIT_VOLTAGE_REFERENCE 29
`define PDC_BIT_COMPARATOR_ONE 30
`define PDC_BIT_COMPARATOR_TWO 31

// Settling window: two instruction cycles of four clocks each
`define PDC_CLOCKS_PER_INSTR 4
`define PDC_SETTLE_INSTR 2
`define PDC_SETTLE_CYCLES (`PDC_SETTLE_INSTR * `PDC_CLOCKS_PER_INSTR)

`endif

// File: hdl/periph_disable_pkg.sv
// Types shared by the peripheral disable bank
package periph_disable_pkg;
	// Gray coded along on -> held -> settle; the settle -> on step flips both bits
	typedef enum logic [1:0] {
		GATE_ON = 2'b00,
		GATE_HELD = 2'b01,
		GATE_SETTLE = 2'b11
	} gate_state_t;

	typedef logic [7:0] reg_byte_t;
	typedef logic [3:0] settle_count_t;
endpackage : periph_disable_pkg

// File: hdl/periph_gate.sv
// Per-peripheral reset hold, output gate and settle tracker
`timescale 1ns/1ns
`include "periph_disable_params.svh"
module periph_gate import periph_disable_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_off,
	output logic o_hold_reset,
	output logic o_out_enable,
	output logic o_ready
);
	gate_state_t state_q, state_d;
	settle_count_t count_q, count_d;
	logic hold_q, hold_d;
	logic out_en_q, out_en_d;
	logic ready_q, ready_d;

	// Next state; a fresh disable during settling goes straight back to held
	always_comb begin
		state_d = state_q;
		count_d = count_q;
		case (state_q)
			GATE_ON: begin
				if (i_off) begin
					state_d = GATE_HELD;
				end
			end
			GATE_HELD: begin
				if (!i_off) begin
					state_d = GATE_SETTLE;
					count_d = settle_count_t'(`PDC_SETTLE_CYCLES);
				end
			end
			GATE_SETTLE: begin
				if (i_off) begin
					state_d = GATE_HELD;
				end else if (count_q <= settle_count_t'(1)) begin
					state_d = GATE_ON;
					count_d = settle_count_t'(0);
				end else begin
					count_d = count_q - settle_count_t'(1);
				end
			end
			default: begin
				state_d = GATE_ON;
				count_d = settle_count_t'(0);
			end
		endcase
		hold_d = (state_d == GATE_HELD);
		out_en_d = (state_d != GATE_HELD);
		ready_d = (state_d == GATE_ON);
	end

	// Reset leaves every peripheral running
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			state_q <= GATE_ON;
			count_q <= 4'h0;
			hold_q <= 1'b0;
			out_en_q <= 1'b1;
			ready_q <= 1'b1;
		end else begin
			state_q <= state_d;
			count_q <= count_d;
			hold_q <= hold_d;
			out_en_q <= out_en_d;
			ready_q <= ready_d;
		end
	end

	assign o_hold_reset = hold_q;
	assign o_out_enable = out_en_q;
	assign o_ready = ready_q;
endmodule : periph_gate

// File: hdl/peripheral_disable_control.sv
// Peripheral disable register bank with APB slave and per-unit gating
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`include "periph_disable_params.svh"

// Summary of operation
// - Every disable bit is zero after any reset; all units run.
// - A unit whose disable bit is set is held in reset.
// - A disabled unit's registers ignore writes and read back zero.
// - A disabled unit's outputs are forced inactive.
// - Clearing a disable bit restarts the unit at power-on values.
// - Register zero disables timer 0 down to nonvolatile access, bit 7 to 0.
// - Clock network off stops full-rate clock; quarter-rate units run on.
// - Nonvolatile access off blocks memory access and control writes.
// - Register one: pulse width 1, capture 2/1, gap, timers 4, 2, 3, 1.
// - Register two: cells 3/2/1, waveform, oscillator, gap, pulse width 2.
// - Register three: comparators, voltage ref, serial, async, cell 4.
// - Implemented disable bits are readable and writable, 8 bits wide.
module peripheral_disable_control import periph_disable_pkg::*; (
	input wire logic i_clk,
	input wire logic i_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [11:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Core access to peripheral registers
	input wire logic i_sfr_req,
	input wire logic i_sfr_write,
	input wire logic [4:0] i_sfr_owner,
	input wire logic [7:0] i_sfr_rdata,
	output logic o_sfr_grant,
	output logic o_sfr_write_en,
	output logic [7:0] o_sfr_rdata,
	// Nonvolatile memory access path
	input wire logic i_nvm_mem_req,
	input wire logic i_nvm_ctrl_write,
	output logic o_nvm_mem_grant,
	output logic o_nvm_ctrl_write_en,
	// Full-rate peripheral clock network enable
	output logic o_sysclk_net_en,
	// Per-unit control, indexed by disable bit position
	output logic [31:0] o_hold_reset,
	output logic [31:0] o_out_enable,
	output logic [31:0] o_periph_ready
);

	// Disable bits as a flat vector {register 3, 2, 1, 0}
	logic [31:0] disable_q, disable_d;

	// APB answer state
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;

	// Gated core access to peripheral registers
	logic sfr_grant_q, sfr_grant_d;
	logic sfr_write_en_q, sfr_write_en_d;
	reg_byte_t sfr_rdata_q, sfr_rdata_d;

	// Nonvolatile memory and clock network gates
	logic nvm_mem_grant_q, nvm_mem_grant_d;
	logic nvm_ctrl_wr_q, nvm_ctrl_wr_d;
	logic sysclk_en_q, sysclk_en_d;

	// Address decode results
	logic addr_hit;
	logic addr_is_ctl;
	logic [1:0] addr_sel;

	// Per-unit ready, hold and output-enable flags, gathered from the gates
	logic [31:0] ready_vec;
	logic [31:0] hold_vec;
	logic [31:0] out_en_vec;

	// Implemented-bit mask in the same layout as the disable vector
	logic [31:0] impl_mask;
	assign impl_mask = {`PDC_IMPL_MASK3, `PDC_IMPL_MASK2,
		`PDC_IMPL_MASK1, `PDC_IMPL_MASK0};

	// Phases of an APB transfer as seen by this slave
	logic apb_access;
	logic apb_first;
	logic apb_commit;
	assign apb_access = i_psel & i_penable;
	assign apb_first = apb_access & ~pready_q;
	assign apb_commit = apb_access & pready_q;

	// Address decode; exact word compare, so unaligned addresses miss
	always_comb begin
		addr_hit = 1'b0;
		addr_is_ctl = 1'b0;
		addr_sel = 2'd0;
		if (i_paddr == `PDC_ADDR_DISABLE0) begin
			addr_hit = 1'b1;
			addr_is_ctl = 1'b1;
			addr_sel = 2'd0;
		end else if (i_paddr == `PDC_ADDR_DISABLE1) begin
			addr_hit = 1'b1;
			addr_is_ctl = 1'b1;
			addr_sel = 2'd1;
		end else if (i_paddr == `PDC_ADDR_DISABLE2) begin
			addr_hit = 1'b1;
			addr_is_ctl = 1'b1;
			addr_sel = 2'd2;
		end else if (i_paddr == `PDC_ADDR_DISABLE3) begin
			addr_hit = 1'b1;
			addr_is_ctl = 1'b1;
			addr_sel = 2'd3;
		end else if (i_paddr == `PDC_ADDR_READY0) begin
			addr_hit = 1'b1;
			addr_sel = 2'd0;
		end else if (i_paddr == `PDC_ADDR_READY1) begin
			addr_hit = 1'b1;
			addr_sel = 2'd1;
		end else if (i_paddr == `PDC_ADDR_READY2) begin
			addr_hit = 1'b1;
			addr_sel = 2'd2;
		end else if (i_paddr == `PDC_ADDR_READY3) begin
			addr_hit = 1'b1;
			addr_sel = 2'd3;
		end
	end

	// APB answer: one wait state, so the answer always comes from flops.
	// Read data and error are sampled in the first access cycle and pready
	// rises for the second; the write lands on that same completing edge.
	always_comb begin
		pready_d = 1'b0;
		pslverr_d = pslverr_q;
		prdata_d = prdata_q;
		if (apb_first) begin
			pready_d = 1'b1;
			pslverr_d = ~addr_hit;
			prdata_d = 32'h0000_0000;
			if (addr_hit && !i_pwrite) begin
				if (addr_is_ctl) begin
					prdata_d[7:0] = disable_q[addr_sel*8 +: 8]
						& impl_mask[addr_sel*8 +: 8];
				end else begin
					prdata_d[7:0] = ready_vec[addr_sel*8 +: 8]
						& impl_mask[addr_sel*8 +: 8];
				end
			end
		end else if (!i_psel) begin
			// Idle bus: drop stale data so nothing leaks between transfers
			pslverr_d = 1'b0;
			prdata_d = 32'h0000_0000;
		end
	end

	// Disable bits; only lane 0 carries data, the upper lanes are ignored.
	// Writes to the read-only ready registers are dropped without error.
	always_comb begin
		disable_d = disable_q;
		if (apb_commit && i_pwrite && addr_hit && addr_is_ctl
			&& i_pstrb[0]) begin
			disable_d[addr_sel*8 +: 8] = i_pwdata[7:0]
				& impl_mask[addr_sel*8 +: 8];
		end
		disable_d = disable_d & impl_mask;
	end

	// Core access to a unit's registers is refused while that unit is off.
	// The owner index follows the disable vector layout; a refused read
	// answers zero and a refused write never reaches the unit.
	always_comb begin
		sfr_grant_d = 1'b0;
		sfr_write_en_d = 1'b0;
		sfr_rdata_d = 8'h00;
		if (i_sfr_req && !disable_q[i_sfr_owner]) begin
			sfr_grant_d = 1'b1;
			sfr_write_en_d = i_sfr_write;
			if (!i_sfr_write) begin
				sfr_rdata_d = i_sfr_rdata;
			end
		end
		if (i_sfr_req && disable_q[i_sfr_owner]) begin
			sfr_rdata_d = 8'h00;
		end
	end

	// Nonvolatile access: memory traffic and control writes both stop
	// while the access bit is set; nothing is queued for later.
	always_comb begin
		nvm_mem_grant_d = i_nvm_mem_req
			& ~disable_q[`PDC_BIT_NONVOLATILE_ACCESS];
		nvm_ctrl_wr_d = i_nvm_ctrl_write
			& ~disable_q[`PDC_BIT_NONVOLATILE_ACCESS];
	end

	// Full-rate clock network enable. The quarter-rate clock has no gate
	// here at all, so units on it keep running whatever this bit says.
	always_comb begin
		sysclk_en_d = ~disable_q[`PDC_BIT_SYSTEM_CLOCK_NET];
	end

	// Register state; all disable bits clear so every unit starts enabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			disable_q <= `PDC_DISABLE_RESET;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q <= 32'h0000_0000;
		end else begin
			disable_q <= disable_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q <= prdata_d;
		end
	end

	// Access gates; reset grants nothing until a request arrives and leaves the clock network enabled
	always_ff @(posedge i_clk or posedge i_rst) begin
		if (i_rst) begin
			sfr_grant_q <= 1'b0;
			sfr_write_en_q <= 1'b0;
			sfr_rdata_q <= 8'h00;
			nvm_mem_grant_q <= 1'b0;
			nvm_ctrl_wr_q <= 1'b0;
			sysclk_en_q <= 1'b1;
		end else begin
			sfr_grant_q <= sfr_grant_d;
			sfr_write_en_q <= sfr_write_en_d;
			sfr_rdata_q <= sfr_rdata_d;
			nvm_mem_grant_q <= nvm_mem_grant_d;
			nvm_ctrl_wr_q <= nvm_ctrl_wr_d;
			sysclk_en_q <= sysclk_en_d;
		end
	end

	// One gate per disable bit. Unimplemented positions never see a set
	// bit, so their gates simply idle in the running state.
	// The settle window covers the two-instruction quiet time software
	// owes after a re-enable; the ready flags let it poll instead of count.
	generate
		for (genvar g = 0; g < 32; g++) begin : gen_gate
			periph_gate u_gate (
				.i_clk(i_clk),
				.i_rst(i_rst),
				.i_off(disable_q[g]),
				.o_hold_reset(hold_vec[g]),
				.o_out_enable(out_en_vec[g]),
				.o_ready(ready_vec[g])
			);
		end
	endgenerate

	// Outputs straight from flops
	assign o_prdata = prdata_q;
	assign o_pready = pready_q;
	assign o_pslverr = pslverr_q;
	assign o_sfr_grant = sfr_grant_q;
	assign o_sfr_write_en = sfr_write_en_q;
	assign o_sfr_rdata = sfr_rdata_q;
	assign o_nvm_mem_grant = nvm_mem_grant_q;
	assign o_nvm_ctrl_write_en = nvm_ctrl_wr_q;
	assign o_sysclk_net_en = sysclk_en_q;
	assign o_hold_reset = hold_vec;
	assign o_out_enable = out_en_vec;
	assign o_periph_ready = ready_vec;

endmodule : peripheral_disable_control

// File: sim/pdc_assertions.sv
// Port-level assertions for the peripheral disable bank
`timescale 1ns/1ns
module pdc_assertions (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic [11:0] i_paddr,
	input wire logic i_sfr_req,
	input wire logic [4:0] i_sfr_owner,
	input wire logic i_nvm_mem_req,
	input wire logic i_nvm_ctrl_write,
	input wire logic o_pready,
	input wire logic o_pslverr,
	input wire logic o_sfr_grant,
	input wire logic [7:0] o_sfr_rdata,
	input wire logic o_nvm_mem_grant,
	input wire logic o_nvm_ctrl_write_en,
	input wire logic o_sysclk_net_en,
	input wire logic [31:0] o_hold_reset,
	input wire logic [31:0] o_out_enable,
	input wire logic [31:0] o_periph_ready
);
	logic unmapped;
	// Only these words answer without error
	assign unmapped = !(i_paddr inside {12'h0430, 12'h0434, 12'h0438,
		12'h043C, 12'h0480, 12'h0484, 12'h0488, 12'h048C});
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_rst);
	sequence s_access;
		i_psel && i_penable && !o_pready;
	endsequence
	// Bit 1 is one of the units the bench restarts; a re-set mid-settle is unused
	sequence s_settle;
		(!o_periph_ready[1] && !o_hold_reset[1]) [*8] ##1 o_periph_ready[1];
	endsequence
	property p_reset_state;
		$fell(i_rst) |-> o_hold_reset == 32'h0000_0000 && o_sysclk_net_en;
	endproperty
	property p_held_idle;
		(o_hold_reset & (o_out_enable | o_periph_ready)) == 32'h0000_0000;
	endproperty
	property p_settle;
		$fell(o_hold_reset[1]) |-> s_settle;
	endproperty
	property p_sfr_grant;
		$past(i_sfr_req) |-> o_sfr_grant == !o_hold_reset[$past(i_sfr_owner)];
	endproperty
	property p_sfr_zero;
		$past(i_sfr_req) && !o_sfr_grant |-> o_sfr_rdata == 8'h00;
	endproperty
	property p_nvm;
		o_nvm_mem_grant || o_nvm_ctrl_write_en |-> !o_hold_reset[0] &&
			$past(i_nvm_mem_req || i_nvm_ctrl_write);
	endproperty
	property p_sysclk;
		o_sysclk_net_en == !o_hold_reset[3];
	endproperty
	property p_pready;
		s_access |=> o_pready ##1 !o_pready;
	endproperty
	property p_err;
		s_access |=> o_pslverr == $past(unmapped);
	endproperty
	a_reset_state: assert property (p_reset_state)
		else $error("Units not enabled after reset");
	a_held_idle: assert property (p_held_idle)
		else $error("Held unit shows output or ready");
	a_settle: assert property (p_settle)
		else $error("Settle window not eight clocks");
	a_sfr_grant: assert property (p_sfr_grant)
		else $error("Unit access grant wrong");
	a_sfr_zero: assert property (p_sfr_zero)
		else $error("Refused read not zero");
	a_nvm: assert property (p_nvm)
		else $error("Memory access passed while off");
	a_sysclk: assert property (p_sysclk)
		else $error("Clock network enable wrong");
	a_pready: assert property (p_pready)
		else $error("Ready not one cycle after access");
	a_err: assert property (p_err)
		else $error("Error response wrong");
endmodule : pdc_assertions
bind peripheral_disable_control pdc_assertions chk_u (.*);

// File: sim/test_peripheral_disable_control.sv
// Directed bench for the peripheral disable bank
`timescale 1ns/1ns
`include "periph_disable_params.svh"
module test_peripheral_disable_control;
	logic i_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_psel = 1'b0, i_penable = 1'b0, i_pwrite = 1'b0;
	logic [11:0] i_paddr = 12'h0000;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [3:0] i_pstrb = 4'hF;
	logic i_sfr_req = 1'b0, i_sfr_write = 1'b0;
	logic [4:0] i_sfr_owner = 5'h00;
	logic [7:0] i_sfr_rdata = 8'h00;
	logic i_nvm_mem_req = 1'b0, i_nvm_ctrl_write = 1'b0;
	logic [31:0] o_prdata, o_hold_reset, o_out_enable, o_periph_ready;
	logic o_pready, o_pslverr, o_sfr_grant, o_sfr_write_en;
	logic [7:0] o_sfr_rdata;
	logic o_nvm_mem_grant, o_nvm_ctrl_write_en, o_sysclk_net_en;
	int n_errors = 0;
	int checks_done = 0;
	logic [31:0] rd, held;
	logic err;
	// Implemented bits per register, gaps read zero
	logic [7:0] msk [4] = '{8'hFF, 8'hEF, 8'hF9, 8'hFF};

	always #4 i_clk = ~i_clk;

	peripheral_disable_control dut_u (.*);

	task automatic report_and_stop;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : report_and_stop

	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// One APB transfer; waits a bounded time for the slave's ready
	task automatic apb(input logic wr, input logic [11:0] a,
		input logic [31:0] d, input logic [3:0] s);
		int k;
		@(posedge i_clk);
		i_psel <= 1'b1;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= d;
		i_pstrb <= s;
		@(posedge i_clk);
		i_penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge i_clk);
			if (o_pready === 1'b1) break;
		end
		if (k == 16) begin
			n_errors++;
			report_and_stop();
		end
		rd = o_prdata;
		err = o_pslverr;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask : apb

	task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0000_0000, 4'hF);
		check("read data", rd, e);
	endtask : rdchk

	// Unit and memory requests for one cycle; answer lands next edge
	task automatic unit(input logic wr, input logic g, input logic [7:0] e);
		@(posedge i_clk);
		i_sfr_req <= 1'b1;
		i_sfr_write <= wr;
		i_sfr_owner <= 5'h01;
		i_sfr_rdata <= 8'hA5;
		i_nvm_mem_req <= 1'b1;
		i_nvm_ctrl_write <= 1'b1;
		@(posedge i_clk);
		i_sfr_req <= 1'b0;
		i_nvm_mem_req <= 1'b0;
		i_nvm_ctrl_write <= 1'b0;
		#1;
		check("grant", o_sfr_grant, g);
		check("write pass", o_sfr_write_en, g & wr);
		check("unit data", o_sfr_rdata, wr ? 8'h00 : e);
		check("mem grant", o_nvm_mem_grant, g);
		check("ctrl write", o_nvm_ctrl_write_en, g);
	endtask : unit

	function automatic logic [11:0] addr_of(input int r);
		return `PDC_ADDR_DISABLE0 + 12'(r * 4);
	endfunction : addr_of

	initial begin
		repeat (8) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int r = 0; r < 4; r++) rdchk(addr_of(r), 32'h0);
		check("hold", o_hold_reset, 32'h0);
		check("ready", o_periph_ready, 32'hFFFF_FFFF);
		$display("reset test done");
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, addr_of(r), 32'hFFFF_FFFF, 4'hF);
			rdchk(addr_of(r), {24'h0, msk[r]});
		end
		held = {msk[3], msk[2], msk[1], msk[0]};
		check("hold", o_hold_reset, held);
		check("out en", o_out_enable, ~held);
		check("ready", o_periph_ready, ~held);
		check("sysclk", o_sysclk_net_en, 1'b0);
		apb(1'b1, addr_of(1), 32'h0, 4'hE);
		rdchk(addr_of(1), 32'h0000_00EF);
		apb(1'b0, 12'h0440, 32'h0, 4'hF);
		check("slverr", err, 1'b1);
		check("err data", rd, 32'h0);
		unit(1'b0, 1'b0, 8'h00);
		unit(1'b1, 1'b0, 8'h00);
		$display("disable test done");
		apb(1'b1, addr_of(0), 32'h0, 4'hF);
		held = held & 32'hFFFF_FF00;
		@(posedge i_clk);
		#1;
		check("hold", o_hold_reset, held);
		check("out en", o_out_enable, ~held);
		check("sysclk", o_sysclk_net_en, 1'b1);
		repeat (7) @(posedge i_clk);
		#1;
		check("ready", o_periph_ready[7:0], 8'h00);
		@(posedge i_clk);
		#1;
		check("ready", o_periph_ready, ~held);
		rdchk(12'h0480, 32'h0000_00FF);
		rdchk(12'h0484, 32'h0);
		unit(1'b0, 1'b1, 8'hA5);
		unit(1'b1, 1'b1, 8'hA5);
		$display("enable test done");
		@(posedge i_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clk);
		i_rst <= 1'b0;
		for (int r = 1; r < 4; r++) rdchk(addr_of(r), 32'h0);
		check("hold", o_hold_reset, 32'h0);
		$display("second reset test done");
		report_and_stop();
	end
endmodule : test_peripheral_disable_control
